/* File: rtl/sld_pkg.sv */
// Constants and types shared by the deframer and its transport mapper
`default_nettype none
package sld_pkg;
   // Register map and reset values
   localparam logic [11:0] SLD_ADDR_LATENCY = 12'h302;
   localparam logic [11:0] SLD_ADDR_MF_OFFSET = 12'h304;
   localparam logic [11:0] SLD_ADDR_BUF_VAR = 12'h306;
   localparam logic [7:0] SLD_RST_LATENCY = 8'h00;
   localparam logic [7:0] SLD_RST_MF_OFFSET = 8'h00;
   localparam logic [7:0] SLD_RST_BUF_VAR = 8'h00;
   localparam logic [7:0] SLD_RDATA_UNMAPPED = 8'h00;

   // Link parameters
   localparam int SLD_MAX_LANES = 8;
   localparam int SLD_WORD_OCTETS = 4;
   localparam int SLD_SMP_BITS = 16;
   localparam logic [5:0] SLD_K_FRAMES = 6'h20;
   localparam logic [1:0] SLD_NUM_CONV = 2'h2;
   localparam logic [4:0] SLD_RES_BITS = 5'h10;
   localparam logic [4:0] SLD_NP_BITS = 5'h10;
   localparam logic [5:0] SLD_MF_WORDS_PER_OCTET = 6'h08;
   localparam logic [11:0] SLD_MF_DAC_PER_INTERP_S = 12'h020;

   // Receive buffer delay limits and receiver delays, in word clocks
   localparam logic [7:0] SLD_RBD_MAX = 8'h0A;
   localparam logic [7:0] SLD_RX_FIXED_DELAY = 8'h0C;
   localparam logic [7:0] SLD_RX_VAR_DELAY = 8'h02;

   // Receive buffer depth covers one longest multiframe plus the delay range
   localparam int SLD_BUF_AW = 6;
   localparam int SLD_BUF_DEPTH = 64;

   typedef enum logic [1:0] {
      SLD_IDLE = 2'b00,
      SLD_ILAS = 2'b01,
      SLD_WAIT = 2'b11,
      SLD_RUN = 2'b10
   } sld_state_t;
endpackage : sld_pkg
`default_nettype wire

/* File: rtl/sld_xport_map.sv */
// Transport layer mapping of one word clock of lane octets to samples
`default_nettype none
module sld_xport_map
   import sld_pkg::*;
(
   input wire logic [SLD_MAX_LANES-1:0][31:0] word_in,
   input wire logic [3:0] lanes,
   input wire logic [2:0] octets,
   input wire logic [1:0] spf,
   output logic [SLD_MAX_LANES-1:0][15:0] conv0_smp,
   output logic [SLD_MAX_LANES-1:0][15:0] conv1_smp
);
   // Octet b of a lane word sits in bits [31-8b -: 8], first octet highest
   always_comb begin
      int f;
      int s;
      int o;
      int smp;
      int sub;
      int idx;
      int hb;
      f = (octets == 3'h0) ? 1 : int'(octets);
      s = (spf == 2'h0) ? 1 : int'(spf);
      o = 0;
      smp = 0;
      sub = 0;
      idx = 0;
      hb = 0;
      conv0_smp = '0;
      conv1_smp = '0;
      for (int l = 0; l < SLD_MAX_LANES; l++) begin
         for (int b = 0; b < SLD_WORD_OCTETS; b++) begin
            // Frame octet index: lane l carries octets l*F .. l*F+F-1
            o = l * f + (b % f);
            smp = o / 2;
            hb = (o % 2 == 0) ? 1 : 0;
            sub = (smp >= s) ? smp - s : smp;
            // Word holds 4/F frames, each with S samples per converter
            idx = (b / f) * s + sub;
            if (l < int'(lanes) && idx < SLD_MAX_LANES) begin
               if (smp >= s) begin
                  conv1_smp[idx][8*hb +: 8] = word_in[l][31-8*b -: 8];
               end else begin
                  conv0_smp[idx][8*hb +: 8] = word_in[l][31-8*b -: 8];
               end
            end
         end
      end
   end
endmodule : sld_xport_map
`default_nettype wire

/* File: rtl/sld_deframer.sv */
// Receive deframer with multiframe alignment, latency readback and buffer release
// Function
// - Latency from local multiframe edge is readable
// - Latency reading wraps at multiframe boundary
// - Receiver adds twelve fixed plus two variable
// - Word clock carries four octets per lane
// - Frames per word clock equal four over F
// - Frames are turned into converter samples
// - Octets per frame must be 1, 2, 4
// - Thirty-two frames per multiframe, two converters
// - Control words and control bits are zero
// - High density off raises configuration error
// - Resolution and sample width are sixteen
// - Lane count must suit interpolation rate
// - Lane count fixes octets and samples
// - Multiframe equals thirty-two words times F/4
// - Local multiframe clock delayed by programmed offset
// - Buffer delay spans zero to ten words
`default_nettype none
module sld_deframer
   import sld_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic link_en,
   input wire logic lmfc_sysref,
   input wire logic lane_valid,
   input wire logic lane_ilas,
   input wire logic [SLD_MAX_LANES-1:0][31:0] lane_data,
   input wire logic [3:0] cfg_lanes,
   input wire logic [2:0] cfg_octets,
   input wire logic [1:0] cfg_spf,
   input wire logic [5:0] cfg_frames,
   input wire logic [1:0] cfg_conv,
   input wire logic [4:0] cfg_res,
   input wire logic [4:0] cfg_np,
   input wire logic cfg_hd,
   input wire logic [4:0] cfg_cf,
   input wire logic [1:0] cfg_cs,
   input wire logic [4:0] cfg_interp,
   input wire logic err_clear,
   output logic smp_valid,
   output logic [SLD_MAX_LANES-1:0][15:0] conv0_smp,
   output logic [SLD_MAX_LANES-1:0][15:0] conv1_smp,
   output logic [3:0] smp_per_conv,
   output logic local_receive_multiframe_clock,
   output logic link_cfg_error,
   output logic lane_setup_error_flag,
   output logic [11:0] mf_period_dac
);
   typedef struct packed {
      sld_state_t st;
      logic [4:0] mf_cnt;
      logic [4:0] lat_cnt;
      logic lmfc_rx;
      logic [7:0] latency;
      logic [7:0] mf_offset;
      logic [7:0] buf_var;
      logic [7:0] rbd_cnt;
      logic lmfc_seen;
      logic [SLD_BUF_AW-1:0] wptr;
      logic [SLD_BUF_AW-1:0] rptr;
      logic err_flag;
      logic cfg_err;
      logic [7:0] rdata;
      logic out_valid;
      logic [SLD_MAX_LANES-1:0][15:0] conv0;
      logic [SLD_MAX_LANES-1:0][15:0] conv1;
      logic [3:0] spc;
      logic [11:0] mf_dac;
   } sld_regs_t;

   sld_regs_t r_q;
   sld_regs_t r_d;
   logic [SLD_MAX_LANES-1:0][31:0] buf_mem [SLD_BUF_DEPTH];
   logic [SLD_MAX_LANES-1:0][31:0] rd_word;
   logic [SLD_MAX_LANES-1:0][15:0] map0;
   logic [SLD_MAX_LANES-1:0][15:0] map1;
   logic [5:0] mf_period;
   logic [4:0] mf_mask;
   logic [4:0] lat_now;
   logic lmfc_now;
   logic first_data;
   logic buf_wr;
   logic cfg_ok;
   logic lane_fs_ok;
   logic interp_ok;

   // Multiframe length in word clocks is K/(4/F) = 8*F
   assign mf_period = SLD_MF_WORDS_PER_OCTET * {3'h0, cfg_octets};
   assign mf_mask = 5'(mf_period - 6'h01);
   // Local edge falls where the aligned count meets the offset
   assign lmfc_now = (r_q.mf_cnt == (r_q.mf_offset[4:0] & mf_mask));
   // Latency counts from each local edge and wraps at the period
   assign lat_now = lmfc_now ? 5'h00 : ((r_q.lat_cnt + 5'h01) & mf_mask);
   assign first_data = (r_q.st == SLD_ILAS) && lane_valid && !lane_ilas;
   assign buf_wr = first_data || ((r_q.st == SLD_WAIT || r_q.st == SLD_RUN) && lane_valid);
   assign rd_word = buf_mem[r_q.rptr];

   // Lane count fixes F and S
   always_comb begin
      case (cfg_lanes)
         4'h1: lane_fs_ok = (cfg_octets == 3'h4) && (cfg_spf == 2'h1);
         4'h2: lane_fs_ok = (cfg_octets == 3'h2) && (cfg_spf == 2'h1);
         4'h3: lane_fs_ok = (cfg_octets == 3'h4) && (cfg_spf == 2'h3);
         4'h4: lane_fs_ok = (cfg_octets == 3'h1) && (cfg_spf == 2'h1);
         4'h6: lane_fs_ok = (cfg_octets == 3'h2) && (cfg_spf == 2'h3);
         4'h8: lane_fs_ok = (cfg_octets == 3'h1) && (cfg_spf == 2'h2);
         default: lane_fs_ok = 1'b0;
      endcase
   end

   // Five and seven lanes never reach here; they fail the check above
   always_comb begin
      case (cfg_interp)
         5'h06: interp_ok = (cfg_lanes >= 4'h3);
         5'h08: interp_ok = (cfg_lanes >= 4'h2);
         5'h0C: interp_ok = (cfg_lanes >= 4'h2);
         5'h10: interp_ok = 1'b1;
         5'h18: interp_ok = 1'b1;
         default: interp_ok = 1'b0;
      endcase
   end

   // F restricted to 1, 2, 4 through the lane table
   assign cfg_ok = lane_fs_ok && interp_ok
      && (cfg_frames == SLD_K_FRAMES) && (cfg_conv == SLD_NUM_CONV)
      && (cfg_cf == 5'h00) && (cfg_cs == 2'h0)
      && cfg_hd
      && (cfg_res == SLD_RES_BITS) && (cfg_np == SLD_NP_BITS);

   sld_xport_map u_map (
      .word_in(rd_word),
      .lanes(cfg_lanes),
      .octets(cfg_octets),
      .spf(cfg_spf),
      .conv0_smp(map0),
      .conv1_smp(map1)
   );

   always_comb begin
      r_d = r_q;
      r_d.lmfc_rx = lmfc_now;
      r_d.lat_cnt = lat_now;
      r_d.cfg_err = link_en && !cfg_ok;
      r_d.out_valid = 1'b0;
      // Samples per converter per word clock are 4*S/F
      r_d.spc = 4'((6'h04 * {4'h0, cfg_spf}) >> (cfg_octets >> 1));
      // Multiframe in DAC clocks: 32 * interpolation * S
      r_d.mf_dac = 12'(SLD_MF_DAC_PER_INTERP_S * {7'h00, cfg_interp} * {10'h000, cfg_spf});

      // Aligned multiframe count restarts on each sysref-aligned edge
      if (lmfc_sysref || r_q.mf_cnt == mf_mask) begin
         r_d.mf_cnt = 5'h00;
      end else begin
         r_d.mf_cnt = r_q.mf_cnt + 5'h01;
      end

      // Register writes; variation saturates so release never overruns
      if (reg_wr_en) begin
         if (reg_addr == SLD_ADDR_MF_OFFSET) begin
            r_d.mf_offset = reg_wdata;
         end else if (reg_addr == SLD_ADDR_BUF_VAR) begin
            r_d.buf_var = (reg_wdata > SLD_RBD_MAX) ? SLD_RBD_MAX : reg_wdata;
         end
      end

      // Read data follows the address one cycle later
      if (reg_addr == SLD_ADDR_LATENCY) begin
         r_d.rdata = r_q.latency;
      end else if (reg_addr == SLD_ADDR_MF_OFFSET) begin
         r_d.rdata = r_q.mf_offset;
      end else if (reg_addr == SLD_ADDR_BUF_VAR) begin
         r_d.rdata = r_q.buf_var;
      end else begin
         r_d.rdata = SLD_RDATA_UNMAPPED;
      end

      // Sticky lane setup flag; a new error wins over a clear
      if (link_en && !cfg_ok) begin
         r_d.err_flag = 1'b1;
      end else if (err_clear) begin
         r_d.err_flag = 1'b0;
      end

      if (buf_wr) begin
         r_d.wptr = r_q.wptr + 1'b1;
      end

      case (r_q.st)
         SLD_IDLE: begin
            r_d.wptr = '0;
            r_d.rptr = '0;
            r_d.lmfc_seen = 1'b0;
            if (link_en && cfg_ok) begin
               r_d.st = SLD_ILAS;
            end
         end
         SLD_ILAS: begin
            if (first_data) begin
               // Latency at the switch from alignment sequence to data
               r_d.latency = {3'h0, lat_now};
               r_d.rbd_cnt = r_q.buf_var;
               r_d.st = SLD_WAIT;
            end
         end
         SLD_WAIT: begin
            // Hold data until the local edge, then the programmed delay
            if (!r_q.lmfc_seen) begin
               r_d.lmfc_seen = lmfc_now;
            end else if (r_q.rbd_cnt == 8'h00) begin
               r_d.st = SLD_RUN;
            end else begin
               r_d.rbd_cnt = r_q.rbd_cnt - 8'h01;
            end
         end
         SLD_RUN: begin
            // Fixed receiver delay sits ahead of this buffer
            r_d.out_valid = 1'b1;
            r_d.conv0 = map0;
            r_d.conv1 = map1;
            r_d.rptr = r_q.rptr + 1'b1;
         end
         default: r_d.st = SLD_IDLE;
      endcase

      // Dropping the link or a bad setup returns to idle from any state
      if (!link_en || !cfg_ok) begin
         r_d.st = SLD_IDLE;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= '0;
         r_q.st <= SLD_IDLE;
         r_q.latency <= SLD_RST_LATENCY;
         r_q.mf_offset <= SLD_RST_MF_OFFSET;
         r_q.buf_var <= SLD_RST_BUF_VAR;
      end else begin
         r_q <= r_d;
      end
   end

   // Data store is plain memory; contents at or past the write pointer are unused
   always_ff @(posedge core_clk) begin
      if (buf_wr) begin
         buf_mem[r_q.wptr] <= lane_data;
      end
   end

   assign reg_rdata = r_q.rdata;
   assign smp_valid = r_q.out_valid;
   assign conv0_smp = r_q.conv0;
   assign conv1_smp = r_q.conv1;
   assign smp_per_conv = r_q.spc;
   assign local_receive_multiframe_clock = r_q.lmfc_rx;
   assign link_cfg_error = r_q.cfg_err;
   assign lane_setup_error_flag = r_q.err_flag;
   assign mf_period_dac = r_q.mf_dac;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   lat_capture_a: assert property (first_data |=>
      r_q.latency == {3'h0, $past(lat_now)})
      else $error("latency not captured at first data");
   lat_readback_a: assert property ((reg_addr == SLD_ADDR_LATENCY) |=>
      reg_rdata == $past(r_q.latency))
      else $error("latency readback mismatch");
   // A smaller F shrinks the period; the count settles one cycle later
   lat_wrap_a: assert property ((cfg_ok && $stable(cfg_octets)) |->
      r_q.lat_cnt <= mf_mask)
      else $error("latency counter beyond multiframe");
   lmfc_offset_a: assert property (lmfc_now |=> local_receive_multiframe_clock)
      else $error("local multiframe edge not shown");
   mf_restart_a: assert property (lmfc_sysref |=>
      r_q.mf_cnt == 5'h00 ##1 r_q.mf_cnt == (5'h01 & mf_mask))
      else $error("multiframe count did not restart");
   var_limit_a: assert property (r_q.buf_var <= SLD_RBD_MAX)
      else $error("buffer variation above ten");
   release_delay_a: assert property ((r_q.st == SLD_WAIT && r_q.lmfc_seen
      && r_q.rbd_cnt == 8'h02 && link_en && cfg_ok) ##1 (link_en && cfg_ok)[*2]
      |=> r_q.st == SLD_RUN)
      else $error("release not after programmed delay");
   cfg_flag_a: assert property ((link_en && !cfg_hd) |=>
      lane_setup_error_flag && link_cfg_error)
      else $error("high density off not flagged");
   out_run_a: assert property (smp_valid |-> $past(r_q.st) == SLD_RUN)
      else $error("samples outside run state");
endmodule : sld_deframer
`default_nettype wire

/* File: tb/sld_tx_model.sv */
// Behavioural lane transmitter: alignment sequence, then continuous data words
`default_nettype none
module sld_tx_model
   import sld_pkg::*;
(
   input wire logic core_clk,
   input wire logic go,
   input wire logic [7:0] ilas_len,
   output logic lane_valid,
   output logic lane_ilas,
   output logic [SLD_MAX_LANES-1:0][31:0] lane_data
);
   timeunit 1ns;
   timeprecision 1ps;
   int k = 0;
   initial begin
      lane_valid = 1'b0;
      lane_ilas = 1'b0;
      lane_data = '0;
   end
   always @(negedge core_clk) begin
      if (!go) begin
         k = 0;
         lane_valid <= 1'b0;
         lane_ilas <= 1'b0;
         // Idle lanes toggle so a stale word never looks like data
         lane_data <= ~lane_data;
      end else begin
         lane_valid <= 1'b1;
         lane_ilas <= (k < ilas_len);
         for (int l = 0; l < SLD_MAX_LANES; l++)
            for (int b = 0; b < SLD_WORD_OCTETS; b++)
               lane_data[l][31-8*b -: 8] <= (k < ilas_len) ? 8'h7C :
                  8'((k - ilas_len) * 32 + l * 4 + b);
         k = k + 1;
      end
   end
endmodule : sld_tx_model
`default_nettype wire

/* File: tb/sld_deframer_bench.sv */
// Self-checking bench: registers, link configuration, latency and sample path
`default_nettype none
module sld_deframer_bench
   import sld_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, link_en = 1'b0;
   logic lmfc_sysref = 1'b0, err_clear = 1'b0, go = 1'b0, cfg_hd, smp_valid, sup;
   logic [11:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, reg_rdata, ilas_len = '0;
   logic [3:0] cfg_lanes, smp_per_conv;
   logic [2:0] cfg_octets;
   logic [1:0] cfg_spf, cfg_conv, cfg_cs;
   logic [5:0] cfg_frames;
   logic [4:0] cfg_res, cfg_np, cfg_cf, cfg_interp;
   logic lane_valid, lane_ilas, local_receive_multiframe_clock;
   logic link_cfg_error, lane_setup_error_flag;
   logic [SLD_MAX_LANES-1:0][31:0] lane_data;
   logic [SLD_MAX_LANES-1:0][15:0] conv0_smp, conv1_smp;
   logic [11:0] mf_period_dac;
   logic seen = 1'b0;
   logic [7:0] vv[4] = '{8'h00, 8'h0A, 8'h0B, 8'hFF};
   int n_fail = 0, cmp_count = 0, cyc = 0, d = 0, p = 0, s = 0;
   int ef, es, lat, tdel, phase, t0, ph0, dmin, dmax;
   int f_of[9] = '{1, 4, 2, 4, 1, 1, 2, 1, 1};
   int s_of[9] = '{1, 1, 1, 3, 1, 1, 3, 1, 2};
   int itv[5] = '{6, 8, 12, 16, 24};

   sld_deframer u_sld_deframer (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_en(link_en),
      .lmfc_sysref(lmfc_sysref), .lane_valid(lane_valid), .lane_ilas(lane_ilas),
      .lane_data(lane_data), .cfg_lanes(cfg_lanes), .cfg_octets(cfg_octets), .cfg_spf(cfg_spf),
      .cfg_frames(cfg_frames), .cfg_conv(cfg_conv), .cfg_res(cfg_res), .cfg_np(cfg_np),
      .cfg_hd(cfg_hd), .cfg_cf(cfg_cf), .cfg_cs(cfg_cs), .cfg_interp(cfg_interp),
      .err_clear(err_clear), .smp_valid(smp_valid), .conv0_smp(conv0_smp),
      .conv1_smp(conv1_smp), .smp_per_conv(smp_per_conv),
      .local_receive_multiframe_clock(local_receive_multiframe_clock),
      .link_cfg_error(link_cfg_error), .lane_setup_error_flag(lane_setup_error_flag),
      .mf_period_dac(mf_period_dac));
   sld_tx_model u_sld_tx_model (.core_clk(core_clk), .go(go), .ilas_len(ilas_len),
      .lane_valid(lane_valid), .lane_ilas(lane_ilas), .lane_data(lane_data));

   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (lmfc_sysref) s = cyc;
      if (lane_valid && !lane_ilas && !seen) begin
         seen = 1'b1;
         d = cyc;
      end
   end
   // Last local edge at or before the first data word
   always @(negedge core_clk) if (local_receive_multiframe_clock && (!seen || cyc == d)) p = cyc;

   task automatic summarize();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr_en = 1'b1;
      tick(1);
      reg_wr_en = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      reg_addr = a;
      tick(1);
      check(reg_rdata, e);
   endtask : rd
   task automatic set_cfg(input int l, input int it);
      ef = f_of[l];
      es = s_of[l];
      cfg_lanes = 4'(l);
      cfg_octets = 3'(ef);
      cfg_spf = 2'(es);
      cfg_interp = 5'(it);
      cfg_frames = SLD_K_FRAMES;
      cfg_conv = SLD_NUM_CONV;
      cfg_res = SLD_RES_BITS;
      cfg_np = SLD_NP_BITS;
      cfg_hd = 1'b1;
      cfg_cf = '0;
      cfg_cs = '0;
   endtask : set_cfg
   // Four lanes, one octet per frame: local multiframe is 8 word clocks
   task automatic run_link(input int il, input int v, input int off);
      int t;
      wr(SLD_ADDR_MF_OFFSET, 8'(off));
      wr(SLD_ADDR_BUF_VAR, 8'(v));
      seen = 1'b0;
      link_en = 1'b1;
      lmfc_sysref = 1'b1;
      tick(1);
      lmfc_sysref = 1'b0;
      ilas_len = 8'(il);
      // Non-blocking so the model, also on this edge, sees go one edge later
      go <= 1'b1;
      t = 0;
      while (smp_valid !== 1'b1 && t < 300) begin
         tick(1);
         t++;
      end
      check(t < 300, 1'b1);
      tdel = cyc - d;
      phase = (p - s) % 8;
      lat = (d - p) % 8;
      for (int b = 0; b < 4; b++) begin
         check(conv0_smp[b], {8'(b), 8'(4 + b)});
         check(conv1_smp[b], {8'(8 + b), 8'(12 + b)});
      end
      go <= 1'b0;
      link_en = 1'b0;
      tick(1);
      rd(SLD_ADDR_LATENCY, 8'(lat));
   endtask : run_link

   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      summarize();
   end
   initial begin
      set_cfg(4, 6);
      tick(10);
      rst_n = 1'b1;
      tick(1);
      rd(SLD_ADDR_LATENCY, SLD_RST_LATENCY);
      rd(SLD_ADDR_MF_OFFSET, SLD_RST_MF_OFFSET);
      rd(SLD_ADDR_BUF_VAR, SLD_RST_BUF_VAR);
      rd(12'h305, SLD_RDATA_UNMAPPED);
      wr(SLD_ADDR_LATENCY, 8'h55);
      rd(SLD_ADDR_LATENCY, SLD_RST_LATENCY);
      foreach (vv[i]) begin
         wr(SLD_ADDR_BUF_VAR, vv[i]);
         rd(SLD_ADDR_BUF_VAR, (vv[i] > SLD_RBD_MAX) ? SLD_RBD_MAX : vv[i]);
      end
      wr(SLD_ADDR_MF_OFFSET, 8'h05);
      rd(SLD_ADDR_MF_OFFSET, 8'h05);
      link_en = 1'b1;
      for (int l = 1; l <= 8; l++) begin
         foreach (itv[i]) begin
            sup = (l inside {3, 4, 6, 8}) || (l == 2 && itv[i] >= 8) || (l == 1 && itv[i] >= 16);
            set_cfg(l, itv[i]);
            tick(3);
            check(link_cfg_error, !sup);
            if (sup) begin
               check(smp_per_conv, 4 * es / ef);
               check(mf_period_dac, 32 * itv[i] * es);
            end
         end
      end
      for (int m = 0; m < 9; m++) begin
         set_cfg(4, 6);
         case (m)
            0: cfg_hd = 1'b0;
            1: cfg_cf = 5'h01;
            2: cfg_cs = 2'h1;
            3: cfg_frames = 6'h1F;
            4: cfg_conv = 2'h1;
            5: cfg_res = 5'h0F;
            6: cfg_np = 5'h0F;
            7: cfg_octets = 3'h3;
            default: cfg_spf = 2'h2;
         endcase
         tick(3);
         check(link_cfg_error, 1'b1);
         set_cfg(4, 6);
         tick(3);
         check(lane_setup_error_flag, 1'b1);
         err_clear = 1'b1;
         tick(1);
         err_clear = 1'b0;
         tick(3);
         check(lane_setup_error_flag, 1'b0);
      end
      link_en = 1'b0;
      for (int n = 0; n < 8; n++) begin
         run_link(20 + n, 0, 0);
         if (n == 4) begin
            t0 = tdel;
            ph0 = phase;
         end
      end
      // Settings identical on every device of the system
      // Known delays in half word clocks: transmitter fixed 13.5, variable 1
      dmin = (2 * SLD_RX_FIXED_DELAY + 27) / 2;
      dmax = (2 * (SLD_RX_FIXED_DELAY + SLD_RX_VAR_DELAY) + 27 + 2 + 1) / 2;
      run_link(24, (dmax + 1) - (dmin - 1), 0);
      check(tdel, t0 + (dmax + 1) - (dmin - 1));
      run_link(24, 15, 0);
      check(tdel, t0 + 10);
      run_link(24, 0, 3);
      check(phase, (ph0 + 3) % 8);
      summarize();
   end
endmodule : sld_deframer_bench
`default_nettype wire
